// ---- cable_tcm_pkg.sv ----
// constants and helper functions for the randomizer and trellis coder
package cable_tcm_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// symbol and randomizer constants
	localparam int          SYM_W        = 7;
	localparam logic [6:0]  RAND_INIT    = 7'h7f;
	localparam logic [6:0]  ALPHA_REDUCE = 7'h09;
	localparam int          RAND_STAGES  = 3;

	////////////////////////////////////////////////////////////////////////////////
	// trellis group geometry
	localparam int          STREAM_W       = 19;
	localparam logic [5:0]  LAST_LOC_256   = 6'h25;
	localparam logic [2:0]  LAST_BIT       = 3'h6;
	localparam logic [1:0]  LAST_SYM_64    = 2'h3;
	localparam logic [2:0]  LAST_QAM       = 3'h4;
	localparam int          UNCODED_W      = 15;
	localparam int          CODED_W        = 4;
	localparam int          PARITY_W       = 5;
	localparam int          SYNC_DATA_BITS = 30;
	localparam int          FRAME_GROUPS   = 2076;
	localparam int          SYNC_GROUPS    = 5;

	// stream index of each serial bit of a pair, most significant bit first
	localparam logic [4:0] FIRST_IDX  [7] = '{5'h0a, 5'h08, 5'h07, 5'h05, 5'h04, 5'h02, 5'h01};
	localparam logic [4:0] SECOND_IDX [7] = '{5'h09, 5'h06, 5'h03, 5'h00, 5'h0d, 5'h0c, 5'h0b};

	// puncture_rows: bit i is time slot i of the group, one means keep
	localparam logic [3:0] PUNCT_G1 = 4'h8;
	localparam logic [3:0] PUNCT_G2 = 4'hf;

	////////////////////////////////////////////////////////////////////////////////
	// 256-QAM frame phase, gray along data -> store -> sync
	typedef enum logic [1:0] {
		PH_DATA  = 2'b00,
		PH_STORE = 2'b01,
		PH_SYNC  = 2'b11
	} frame_phase_t;

	// multiply by alpha in GF(128), alpha^7 = alpha^3 + 1
	function automatic logic [6:0] mul_alpha(input logic [6:0] x);
		mul_alpha = {x[5:0], 1'b0} ^ (x[6] ? ALPHA_REDUCE : 7'h00);
	endfunction

	function automatic logic [6:0] mul_alpha3(input logic [6:0] x);
		mul_alpha3 = mul_alpha(mul_alpha(mul_alpha(x)));
	endfunction

	// stream locations that feed the convolutional coder
	function automatic logic is_coded(input logic m256, input logic [4:0] idx);
		if (m256) begin
			is_coded = (idx <= 5'd12) && (idx[1:0] == 2'b00);
		end else begin
			is_coded = (idx == 5'd0) || (idx == 5'd3) || (idx == 5'd6) || (idx == 5'd9);
		end
	endfunction

endpackage

// ---- binary_conv_encoder.sv ----
// punctured 16-state rate one-half convolutional coder, one group per load
module binary_conv_encoder
	import cable_tcm_pkg::*;
(
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic                load,
	input  wire logic [CODED_W-1:0]  data_bits,
	output logic      [PARITY_W-1:0] parity_bits
);

	logic [3:0] taps_q;
	logic [3:0] taps_d;
	logic [7:0] enc;
	logic [4:0] kept;

	// taps_d[0] is D, taps_d[3] is D^4; state carries across groups
	always_comb begin
		int j;
		j = 0;
		taps_d = taps_q;
		enc = '0;
		kept = '0;
		for (int i = 0; i < CODED_W; i++) begin
			enc[2*i]   = data_bits[i] ^ taps_d[1] ^ taps_d[3];
			enc[2*i+1] = data_bits[i] ^ (^taps_d);
			taps_d = {taps_d[2:0], data_bits[i]};
			// commutator starts at the first generator every group
			if (PUNCT_G1[i]) begin
				kept[j] = enc[2*i];
				j = j + 1;
			end
			if (PUNCT_G2[i]) begin
				kept[j] = enc[2*i+1];
				j = j + 1;
			end
		end
	end

	assign parity_bits = kept;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			taps_q <= 4'h0;
		end else if (load) begin
			taps_q <= taps_d;
		end
	end

endmodule // binary_conv_encoder

// ---- cable_randomizer_trellis_coder.sv ----
// randomizer, trellis grouping, precoder, punctured coders and mapper
module cable_randomizer_trellis_coder
	import cable_tcm_pkg::*;
#(
	parameter int GROUPS_PER_FRAME = FRAME_GROUPS,
	parameter int SYNC_GROUP_COUNT = SYNC_GROUPS
)(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             mode_256,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [SYM_W-1:0] in_data,
	input  wire logic             in_sync,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [7:0]       out_symbol
);

	localparam int STORE_W = SYNC_GROUP_COUNT * SYNC_DATA_BITS;
	localparam logic [11:0] LAST_GROUP = 12'(GROUPS_PER_FRAME - 1);
	localparam logic [11:0] SYNC_START = 12'(GROUPS_PER_FRAME - SYNC_GROUP_COUNT);
	localparam logic [7:0]  STORE_FULL = 8'(STORE_W);

	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [6:0]          rand_q [RAND_STAGES];
	logic [6:0]          sh_q;
	logic [2:0]          sh_cnt_q;
	logic                sh_sync_q;
	logic                in_ready_q;
	logic [2:0]          bitc_q;
	logic [1:0]          symc_q;
	logic [5:0]          loc_q;
	logic [STREAM_W-1:0] grp_a_q;
	logic [STREAM_W-1:0] grp_b_q;
	logic [11:0]         grp_cnt_q;
	frame_phase_t        phase_q;
	logic [STORE_W-1:0]  store_q;
	logic [7:0]          store_cnt_q;
	logic [1:0]          pre_q;
	logic [14:0]         em_a_q;
	logic [14:0]         em_b_q;
	logic [4:0]          em_u_q;
	logic [4:0]          em_v_q;
	logic [2:0]          em_k_q;
	logic                em_busy_q;
	logic                out_valid_q;
	logic [7:0]          out_symbol_q;

	////////////////////////////////////////////////////////////////////////////////
	// input side and serialiser
	wire       accept     = in_valid && in_ready_q;
	wire       sh_has     = sh_cnt_q != 3'h0;
	wire       cur_bit    = sh_q[6];
	wire [6:0] rand_out   = rand_q[RAND_STAGES-1];
	wire       rand_step  = accept && !in_sync;
	wire       rand_load  = accept && in_sync;

	// write position: 64-QAM from symbol and bit slot, 256-QAM from location
	wire [4:0] idx_64     = symc_q[0] ? SECOND_IDX[bitc_q] : FIRST_IDX[bitc_q];
	wire       wr_stream  = mode_256 ? loc_q[0] : symc_q[1];
	wire [4:0] wr_idx     = mode_256 ? loc_q[5:1] : idx_64;
	wire       coded_here = is_coded(mode_256, wr_idx);
	wire       last_loc   = mode_256 ? (loc_q == LAST_LOC_256)
	                                 : (symc_q == LAST_SYM_64 && bitc_q == LAST_BIT);
	// a finished group waits while the previous one is still being emitted
	wire       place_room = !last_loc || !em_busy_q;

	wire in_sync_grp  = mode_256 && phase_q == PH_SYNC;
	wire from_store   = in_sync_grp && !coded_here && place_room;
	wire take_trailer = in_sync_grp && coded_here && sh_has && sh_sync_q && place_room;
	wire plain_64     = !mode_256 && sh_has && place_room;
	wire plain_256    = mode_256 && phase_q == PH_DATA && sh_has && !sh_sync_q && place_room;
	wire push         = mode_256 && phase_q == PH_STORE && sh_has && !sh_sync_q;
	// trailer bits outside the sync groups carry no place in a 256-QAM frame
	wire drop         = mode_256 && sh_has && sh_sync_q && phase_q != PH_SYNC;
	wire place        = from_store || take_trailer || plain_64 || plain_256;
	wire place_bit    = from_store ? store_q[STORE_W-1] : cur_bit;
	wire consume      = take_trailer || plain_64 || plain_256 || push || drop;
	wire grp_done     = place && last_loc;
	wire store_done   = push && (store_cnt_q + 8'h01 == STORE_FULL);

	logic [2:0] sh_cnt_d;
	assign sh_cnt_d = accept ? (in_sync ? 3'h1 : 3'h7)
	                         : (consume ? sh_cnt_q - 3'h1 : sh_cnt_q);

	////////////////////////////////////////////////////////////////////////////////
	// group contents including the bit written this cycle
	logic [STREAM_W-1:0] grp_a_d;
	logic [STREAM_W-1:0] grp_b_d;
	always_comb begin
		grp_a_d = grp_a_q;
		grp_b_d = grp_b_q;
		if (place && !wr_stream) begin
			grp_a_d[wr_idx] = place_bit;
		end
		if (place && wr_stream) begin
			grp_b_d[wr_idx] = place_bit;
		end
	end

	// split a stream into coder bits (ascending slot, lsb first) and uncoded bits
	function automatic logic [CODED_W+UNCODED_W-1:0] split_stream(
		input logic m256, input logic [STREAM_W-1:0] s);
		logic [CODED_W-1:0]   c;
		logic [UNCODED_W-1:0] u;
		int ci;
		int ui;
		c = '0;
		u = '0;
		ci = 0;
		ui = 0;
		for (int i = 0; i < STREAM_W; i++) begin
			if (is_coded(m256, 5'(i))) begin
				if (ci < CODED_W) c[ci] = s[i];
				ci = ci + 1;
			end else if (ui < UNCODED_W) begin
				u[ui] = s[i];
				ui = ui + 1;
			end
		end
		split_stream = {c, u};
	endfunction

	wire [CODED_W+UNCODED_W-1:0] split_a = split_stream(mode_256, grp_a_d);
	wire [CODED_W+UNCODED_W-1:0] split_b = split_stream(mode_256, grp_b_d);

	// precoder: quadrant state advances by each coded bit pair, mod four
	logic [1:0]         pre_d;
	logic [CODED_W-1:0] pc_a;
	logic [CODED_W-1:0] pc_b;
	always_comb begin
		pre_d = pre_q;
		pc_a = '0;
		pc_b = '0;
		for (int i = 0; i < CODED_W; i++) begin
			pre_d = pre_d + {split_a[UNCODED_W+i], split_b[UNCODED_W+i]};
			pc_a[i] = pre_d[1];
			pc_b[i] = pre_d[0];
		end
	end

	logic [PARITY_W-1:0] first_stream_parity_bits;
	logic [PARITY_W-1:0] second_stream_parity_bits;

	binary_conv_encoder u_coder_a (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.load        (grp_done),
		.data_bits   (pc_a),
		.parity_bits (first_stream_parity_bits)
	);

	binary_conv_encoder u_coder_b (
		.sys_clk     (sys_clk),
		.rst         (rst),
		.load        (grp_done),
		.data_bits   (pc_b),
		.parity_bits (second_stream_parity_bits)
	);

	////////////////////////////////////////////////////////////////////////////////
	// mapper: the constellation label is the direct bit address of both streams
	function automatic logic [7:0] map_symbol(input logic m256, input logic [2:0] k,
		input logic [14:0] a, input logic [14:0] b, input logic [4:0] u, input logic [4:0] v);
		if (m256) begin
			map_symbol = {a[3*k +: 3], u[k], b[3*k +: 3], v[k]};
		end else begin
			map_symbol = {2'b00, a[2*k +: 2], u[k], b[2*k +: 2], v[k]};
		end
	endfunction

	wire [7:0] next_symbol = map_symbol(mode_256, em_k_q, em_a_q, em_b_q, em_u_q, em_v_q);
	wire       out_free    = !out_valid_q || out_ready;
	wire       emit        = em_busy_q && out_free;

	////////////////////////////////////////////////////////////////////////////////
	// randomizer: oldest stage is the output tap
	always_ff @(posedge sys_clk) begin
		if (rst || rand_load) begin
			for (int i = 0; i < RAND_STAGES; i++) begin
				rand_q[i] <= RAND_INIT;
			end
		end else if (rand_step) begin
			rand_q[2] <= rand_q[1];
			rand_q[1] <= rand_q[0];
			rand_q[0] <= rand_q[1] ^ mul_alpha3(rand_q[2]);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sh_q      <= 7'h00;
			sh_sync_q <= 1'b0;
		end else if (accept) begin
			// trailer bits go out clear, one bit per transfer
			sh_q      <= in_sync ? {in_data[0], 6'h00} : in_data ^ rand_out;
			sh_sync_q <= in_sync;
		end else if (consume) begin
			sh_q      <= {sh_q[5:0], 1'b0};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sh_cnt_q   <= 3'h0;
			in_ready_q <= 1'b0;
		end else begin
			sh_cnt_q   <= sh_cnt_d;
			in_ready_q <= sh_cnt_d == 3'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// group location counters
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bitc_q <= 3'h0;
			symc_q <= 2'h0;
			loc_q  <= 6'h00;
		end else if (place) begin
			if (mode_256) begin
				// a sync group steps through every location from 0, and coded slot 0 holds a trailer bit
				loc_q <= last_loc ? 6'h00 : loc_q + 6'h01;
			end else begin
				bitc_q <= (bitc_q == LAST_BIT) ? 3'h0 : bitc_q + 3'h1;
				if (bitc_q == LAST_BIT) begin
					symc_q <= symc_q + 2'h1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || grp_done) begin
			grp_a_q <= '0;
			grp_b_q <= '0;
		end else begin
			grp_a_q <= grp_a_d;
			grp_b_q <= grp_b_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// 256-QAM frame tracking and sync group data store
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			grp_cnt_q <= 12'h000;
			phase_q   <= PH_DATA;
		end else begin
			unique case (phase_q)
				PH_DATA: if (grp_done && mode_256) begin
					grp_cnt_q <= grp_cnt_q + 12'h001;
					if (grp_cnt_q + 12'h001 == SYNC_START) begin
						phase_q <= PH_STORE;
					end
				end
				PH_STORE: if (store_done) begin
					phase_q <= PH_SYNC;
				end
				PH_SYNC: if (grp_done) begin
					grp_cnt_q <= (grp_cnt_q == LAST_GROUP) ? 12'h000 : grp_cnt_q + 12'h001;
					if (grp_cnt_q == LAST_GROUP) begin
						phase_q <= PH_DATA;
					end
				end
				default: phase_q <= PH_DATA;
			endcase
		end
	end

	// holds the last frame data until the trailer bits arrive to share the groups
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			store_q     <= '0;
			store_cnt_q <= 8'h00;
		end else if (push) begin
			store_q     <= {store_q[STORE_W-2:0], cur_bit};
			store_cnt_q <= store_cnt_q + 8'h01;
		end else if (from_store) begin
			store_q     <= {store_q[STORE_W-2:0], 1'b0};
			store_cnt_q <= store_cnt_q - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// emission of five symbols per group
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pre_q     <= 2'h0;
			em_a_q    <= '0;
			em_b_q    <= '0;
			em_u_q    <= '0;
			em_v_q    <= '0;
			em_k_q    <= 3'h0;
			em_busy_q <= 1'b0;
		end else if (grp_done) begin
			pre_q     <= pre_d;
			em_a_q    <= split_a[UNCODED_W-1:0];
			em_b_q    <= split_b[UNCODED_W-1:0];
			em_u_q    <= first_stream_parity_bits;
			em_v_q    <= second_stream_parity_bits;
			em_k_q    <= 3'h0;
			em_busy_q <= 1'b1;
		end else if (emit) begin
			em_k_q    <= em_k_q + 3'h1;
			em_busy_q <= em_k_q != LAST_QAM;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			out_valid_q  <= 1'b0;
			out_symbol_q <= 8'h00;
		end else if (emit) begin
			out_valid_q  <= 1'b1;
			out_symbol_q <= next_symbol;
		end else if (out_ready) begin
			out_valid_q  <= 1'b0;
		end
	end

	assign in_ready   = in_ready_q;
	assign out_valid  = out_valid_q;
	assign out_symbol = out_symbol_q;

endmodule // cable_randomizer_trellis_coder

// ---- cable_tcm_chk.sv ----
// port-level assertion checker for the randomizer and trellis coder
module cable_tcm_chk
	import cable_tcm_pkg::*;
#(
	parameter int GROUPS_PER_FRAME = FRAME_GROUPS,
	parameter int SYNC_GROUP_COUNT = SYNC_GROUPS
)(
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire logic             mode_256,
	input wire logic             in_valid,
	input wire logic             in_ready,
	input wire logic [SYM_W-1:0] in_data,
	input wire logic             in_sync,
	input wire logic             out_valid,
	input wire logic             out_ready,
	input wire logic [7:0]       out_symbol
);
	////////////////////////////////
	// sym_q is the index of the symbol on offer within its group
	logic [2:0]  sym_q;
	logic [2:0]  sym_d;
	int unsigned bits_q;
	int unsigned bits_d;
	int unsigned outs_q;
	int unsigned outs_d;
	wire         take_in  = in_valid && in_ready;
	wire         take_out = out_valid && out_ready;
	assign sym_d  = !take_out ? sym_q : (sym_q == 3'h4) ? 3'h0 : sym_q + 3'h1;
	assign bits_d = bits_q + (!take_in ? 0 : in_sync ? 1 : 7);
	assign outs_d = outs_q + (take_out ? 1 : 0);
	always_ff @(posedge sys_clk) begin
		sym_q  <= rst ? 3'h0 : sym_d;
		bits_q <= rst ? 0 : bits_d;
		outs_q <= rst ? 0 : outs_d;
	end
	////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	hold_sym_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_symbol))
		else $error("symbol changed before it was taken");
	sym_width_a: assert property (out_valid && !mode_256 |-> out_symbol[7:6] == 2'b00)
		else $error("64-QAM symbol wider than six bits");
	data_gap_a: assert property (take_in && !in_sync |=> !in_ready [*7])
		else $error("data symbol not serialised over seven cycles");
	trailer_gap_a: assert property (take_in && in_sync |=> !in_ready)
		else $error("trailer bit taken back to back");
	// in_ready is registered from an empty serialiser, so it is up one edge after release
	reset_idle_a: assert property ($fell(rst) |-> !in_ready && !out_valid && out_symbol == 8'h00 ##1 in_ready)
		else $error("wrong state after reset release");
	group_end_a: assert property ($fell(out_valid) |-> sym_q == 3'h0)
		else $error("output stopped inside a group");
	burst_run_a: assert property (take_out && sym_q != 3'h4 |=> out_valid)
		else $error("group of five symbols broken");
	emit_bound_a: assert property (!mode_256 |-> outs_q * 28 <= bits_q * 5)
		else $error("more symbols emitted than bits received");
	cover property ($fell(out_valid));
	cover property (take_in && in_sync);
	cover property (mode_256 && take_out);
endmodule // cable_tcm_chk

bind cable_randomizer_trellis_coder cable_tcm_chk #(
	.GROUPS_PER_FRAME(GROUPS_PER_FRAME),
	.SYNC_GROUP_COUNT(SYNC_GROUP_COUNT)
) i_cable_tcm_chk (
	.sys_clk(sys_clk), .rst(rst), .mode_256(mode_256), .in_valid(in_valid),
	.in_ready(in_ready), .in_data(in_data), .in_sync(in_sync), .out_valid(out_valid),
	.out_ready(out_ready), .out_symbol(out_symbol)
);

// ---- qam_sink_model.sv ----
// downstream modulator model that collects symbols and can stall
module qam_sink_model (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       stall,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_symbol,
	output logic            out_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] got [$];
	int         phase = 0;
	initial out_ready = 1'b0;
	// a slow modulator is ready one cycle in three while stall is high, so the coder must hold its output
	always @(posedge sys_clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			got.push_back(out_symbol);
		end
		phase = (phase + 1) % 3;
		#1;
		out_ready = !rst && (!stall || phase == 0);
	end
endmodule // qam_sink_model

// ---- tb_cable_randomizer_trellis_coder.sv ----
// self-checking testbench for the randomizer and trellis coder
`define CHK(what, exp, act) \
	begin \
		n_compared++; \
		if ((act) !== (exp)) begin \
			num_errors++; \
			$display("[FAIL] %s expected %h seen %h", what, exp, act); \
		end \
	end
module tb_cable_randomizer_trellis_coder
	import cable_tcm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [41:0] TRAILER = 42'h2d5_a6c9_e0f2;
	localparam int          UNC [6] = '{1, 2, 3, 5, 6, 7};
	logic             sys_clk    = 1'b0;
	logic             rst        = 1'b1;
	logic             mode_256   = 1'b0;
	logic             in_valid   = 1'b0;
	logic [SYM_W-1:0] in_data    = 7'h00;
	logic             in_sync    = 1'b0;
	logic             stall      = 1'b0;
	logic             in_ready;
	logic             out_valid;
	logic             out_ready;
	logic [7:0]       out_symbol;
	int               num_errors = 0;
	int               n_compared = 0;
	int               cyc        = 0;
	int               base       = 0;
	always #10 sys_clk = ~sys_clk;
	// 11 groups: 6 ordinary ones then 5 sync ones hold exactly 54 symbols
	cable_randomizer_trellis_coder #(
		.GROUPS_PER_FRAME(11),
		.SYNC_GROUP_COUNT(5)
	) i_cable_randomizer_trellis_coder (
		.sys_clk(sys_clk), .rst(rst), .mode_256(mode_256), .in_valid(in_valid),
		.in_ready(in_ready), .in_data(in_data), .in_sync(in_sync), .out_valid(out_valid),
		.out_ready(out_ready), .out_symbol(out_symbol)
	);
	qam_sink_model i_qam_sink_model (
		.sys_clk(sys_clk), .rst(rst), .stall(stall), .out_valid(out_valid),
		.out_symbol(out_symbol), .out_ready(out_ready)
	);
	////////////////////////////////
	task automatic finish_test();
		if (num_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task automatic do_reset(input logic m);
		rst      = 1'b1;
		mode_256 = m;
		repeat (20) @(posedge sys_clk);
		#1;
		rst  = 1'b0;
		base = i_qam_sink_model.got.size();
	endtask
	// holds the word until the edge that takes it; valid stays up for the next call
	task automatic put(input logic [6:0] d, input logic s);
		int n;
		n        = 0;
		in_valid = 1'b1;
		in_data  = d;
		in_sync  = s;
		while (in_ready !== 1'b1 && n < 500) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		@(posedge sys_clk);
		#1;
	endtask
	task automatic wait_out(input int n);
		int t;
		t        = 0;
		in_valid = 1'b0;
		while (i_qam_sink_model.got.size() - base < n && t < 3000) begin
			@(posedge sys_clk);
			#1;
			t++;
		end
		repeat (20) @(posedge sys_clk);
		#1;
	endtask
	function automatic logic [6:0] dsym(input int i);
		return 7'(i * 37 + 5);
	endfunction
	function automatic logic [1:0] pick64(input logic [6:0] f, input logic [6:0] s, input int k);
		logic [9:0] u;
		u = {s[2:0], f};
		return u[2 * k +: 2];
	endfunction
	function automatic logic [2:0] pick256(input logic [20:0] x, input int k, input int st);
		logic [2:0] r;
		for (int m = 0; m < 3; m++) begin
			r[m] = x[20 - 2 * UNC[3 * k + m] - st];
		end
		return r;
	endfunction
	// pseudo_noise symbol n after a reload, three stages, new = mid ^ alpha^3 * oldest
	function automatic logic [6:0] pn_ref(input int n);
		logic [6:0] s [3];
		logic [6:0] t;
		s[0] = 7'h7f;
		s[1] = 7'h7f;
		s[2] = 7'h7f;
		for (int i = 0; i < n; i++) begin
			t = s[2];
			for (int m = 0; m < 3; m++) begin
				t = {t[5:0], 1'b0} ^ {3'b000, t[6], 2'b00, t[6]};
			end
			s[2] = s[1];
			s[1] = s[0];
			s[0] = s[2] ^ t;
		end
		return s[2];
	endfunction
	// parity of the first group after reset, zero precoder and coder state, as {u, v}
	function automatic logic [9:0] parity_ref(input logic [6:0] sa, input logic [6:0] sb);
		logic [1:0] y;
		logic [4:0] wa;
		logic [4:0] wb;
		logic [4:0] u;
		logic [4:0] v;
		y  = 2'b00;
		wa = 5'h00;
		wb = 5'h00;
		u  = 5'h00;
		v  = 5'h00;
		for (int i = 0; i < 4; i++) begin
			y  = y + {sa[3 + i], sb[3 + i]};
			wa = {wa[3:0], y[1]};
			wb = {wb[3:0], y[0]};
			if (i == 3) begin
				u[3] = ^(wa & 5'h15);
				v[3] = ^(wb & 5'h15);
			end
			u[(i == 3) ? 4 : i] = ^wa;
			v[(i == 3) ? 4 : i] = ^wb;
		end
		return {u, v};
	endfunction
	task automatic chk64(input int g, input logic [6:0] fa, sa, fb, sb, input int nb);
		logic [7:0] v;
		for (int k = 0; k < 5; k++) begin
			v = i_qam_sink_model.got[base + g * 5 + k];
			`CHK("sym64_top", 2'b00, v[7:6])
			`CHK("a64_uncoded", pick64(fa, sa, k), v[5:4])
			if (k < nb) `CHK("b64_uncoded", pick64(fb, sb, k), v[2:1])
		end
	endtask
	task automatic chk256(input int g, input logic [20:0] x);
		logic [7:0] v;
		for (int k = 0; k < 2; k++) begin
			v = i_qam_sink_model.got[base + g * 5 + k];
			`CHK("a256_uncoded", pick256(x, k, 0), v[7:5])
			`CHK("b256_uncoded", pick256(x, k, 1), v[3:1])
		end
	endtask
	////////////////////////////////
	task automatic scen_64_group();
		logic [6:0] w [4];
		logic [9:0] p;
		logic [7:0] v;
		do_reset(1'b0);
		for (int i = 0; i < 4; i++) begin
			put(dsym(i), 1'b0);
			w[i] = dsym(i) ^ pn_ref(i);
		end
		wait_out(5);
		`CHK("group64_syms", 5, i_qam_sink_model.got.size() - base)
		chk64(0, w[0], w[1], w[2], w[3], 5);
		p = parity_ref(w[1], w[3]);
		for (int k = 0; k < 5; k++) begin
			v = i_qam_sink_model.got[base + k];
			`CHK("u64_parity", p[5 + k], v[3])
			`CHK("v64_parity", p[k], v[0])
		end
	endtask
	// trailer straddles groups: one full trailer group, then half trailer half data
	task automatic scen_64_trailer();
		stall = 1'b1;
		for (int i = 0; i < 4; i++) begin
			put(dsym(i + 4), 1'b0);
		end
		for (int i = 0; i < 42; i++) begin
			put({6'h00, TRAILER[41 - i]}, 1'b1);
		end
		put(dsym(0), 1'b0);
		put(dsym(1), 1'b0);
		wait_out(20);
		`CHK("trailer64_syms", 20, i_qam_sink_model.got.size() - base)
		chk64(2, TRAILER[41:35], TRAILER[34:28], TRAILER[27:21], TRAILER[20:14], 5);
		chk64(3, TRAILER[13:7], TRAILER[6:0], dsym(0) ^ 7'h7f, dsym(1) ^ 7'h7f, 3);
	endtask
	task automatic scen_256_frame();
		logic [13:0] y;
		logic [7:0]  v;
		do_reset(1'b1);
		for (int i = 0; i < 54; i++) begin
			put(dsym(i), 1'b0);
		end
		for (int i = 0; i < 40; i++) begin
			put({6'h00, TRAILER[41 - i]}, 1'b1);
		end
		for (int i = 0; i < 6; i++) begin
			put(dsym(i), 1'b0);
		end
		wait_out(60);
		`CHK("frame256_syms", 60, i_qam_sink_model.got.size() - base)
		chk256(0, {dsym(0), dsym(1), dsym(2)} ^ {3{7'h7f}});
		chk256(11, {dsym(0), dsym(1), dsym(2)} ^ {3{7'h7f}});
		// first sync group: stored data resumes at A1 with frame bit 228, mid symbol 32
		y = {dsym(32) ^ pn_ref(32), dsym(33) ^ pn_ref(33)};
		v = i_qam_sink_model.got[base + 30];
		`CHK("a256_sync", {y[5], y[7], y[9]}, v[7:5])
		`CHK("b256_sync", {y[4], y[6], y[8]}, v[3:1])
	endtask
	initial begin
		scen_64_group();
		scen_64_trailer();
		scen_256_frame();
		finish_test();
	end
endmodule // tb_cable_randomizer_trellis_coder
